// ===== icfm_pkg.sv
package icfm_pkg;
  localparam int unsigned NUM_LINES = 16;
  localparam int unsigned VEC_W     = 6;
  localparam int unsigned PC_W      = 16;
  // status register zero: global mask bit position
  localparam int unsigned GLOBAL_MASK_POS = 9;
  // reset values
  localparam logic [15:0] PEND_RST   = 16'h0000;
  localparam logic [15:0] ENMASK_RST = 16'h0000;
  localparam logic        GMASK_RST  = 1'h1;
  localparam logic [15:0] PC_RST     = 16'h0000;
  // vector table layout: base plus two words per line
  localparam logic [15:0] VEC_BASE   = 16'h0002;
  localparam logic [15:0] NMI_VEC    = 16'h0024;
  localparam logic [15:0] SWI_VEC    = 16'h0026;
  localparam int unsigned VEC_SHIFT  = 1;

  typedef enum logic [1:0] {
    ICFM_IDLE  = 2'b00,
    ICFM_ACK   = 2'b01,
    ICFM_SERVE = 2'b10
  } icfm_state_t;

  // software write port toward the three registers
  typedef struct packed {
    logic        pend_wr;
    logic        mask_wr;
    logic        gmask_wr;
    logic        gmask_val;
    logic [15:0] data;
  } icfm_wr_t;

  // acknowledge record toward program fetch
  typedef struct packed {
    logic        ack;
    logic [15:0] vector_addr;
    logic [3:0]  line;
    logic        nmi;
  } icfm_ack_t;
endpackage

// ===== icfm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for asynchronous request pins
module icfm_sync #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = i_async;
    next_sync   = stage1;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule // icfm_sync
`default_nettype wire

// ===== icfm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module icfm_ctrl
  import icfm_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_sys_rst,
  // request sources
  input  wire logic [15:0]            i_pin_req,
  input  wire logic [15:0]            i_periph_req,
  input  wire logic                   i_nmi_pin,
  input  wire logic                   i_swi_valid,
  input  wire logic [3:0]             i_swi_line,
  input  wire logic                   i_trap_valid,
  input  wire logic                   i_nmi_instr,
  // software register writes
  input  wire icfm_pkg::icfm_wr_t     i_wr,
  // core fetch interface
  input  wire logic                   i_core_ready,
  input  wire logic [15:0]            i_cur_pc,
  input  wire logic                   i_return,
  // register views
  output logic [15:0]                 o_pending_flag_register,
  output logic [15:0]                 o_interrupt_enable_mask_register,
  output logic                        o_global_mask_bit,
  // acknowledge and program counter control
  output icfm_pkg::icfm_ack_t         o_vector_fetch_ack,
  output logic                        o_pc_load,
  output logic [15:0]                 o_pc_value,
  output logic                        o_in_service
);
  import icfm_pkg::*;

  logic [15:0] pin_sync;
  logic        nmi_sync;
  logic        nmi_prev;
  logic [15:0] pin_prev;
  logic        next_nmi_prev;
  logic [15:0] next_pin_prev;

  icfm_sync #(.W(17)) u_sync (
    .i_clock  (i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async  ({i_nmi_pin, i_pin_req}),
    .o_sync   ({nmi_sync, pin_sync})
  );

  // edge history of the synchronised pins; resets to the idle low level
  // so no false edge follows reset
  always_comb begin
    next_pin_prev = pin_sync;
    next_nmi_prev = nmi_sync;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_prev <= 16'h0000;
      nmi_prev <= 1'b0;
    end else begin
      pin_prev <= next_pin_prev;
      nmi_prev <= next_nmi_prev;
    end
  end

  // lowest set bit wins, returns index
  function automatic logic [3:0] pick_line(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] onehot(input logic [3:0] n);
    return 16'h0001 << n;
  endfunction

  icfm_state_t state;
  icfm_state_t next_state;
  logic [15:0] pend;
  logic [15:0] next_pend;
  logic [15:0] enmask;
  logic [15:0] next_enmask;
  logic        gmask;
  logic        next_gmask;
  logic        nmi_pend;
  logic        next_nmi_pend;
  logic [15:0] saved_pc;
  logic [15:0] next_saved_pc;
  icfm_ack_t   next_ack;
  logic        next_pc_load;
  logic [15:0] next_pc_value;
  logic [15:0] set_vec;
  logic [15:0] eligible;
  logic [15:0] clr_ack;
  logic [3:0]  sel;
  logic        nmi_evt;
  logic        next_in_service;

  always_comb begin
    // pin edges, peripheral levels and instructions all raise requests
    // request sources
    set_vec = (pin_sync & ~pin_prev) | i_periph_req;
    if (i_swi_valid) begin
      set_vec = set_vec | onehot(i_swi_line);
    end
    nmi_evt  = (nmi_sync & ~nmi_prev) | i_nmi_instr | i_trap_valid;
    eligible = pend & enmask & {NUM_LINES{~gmask}};
    sel      = pick_line(eligible);
    clr_ack  = 16'h0000;

    next_state    = state;
    next_gmask    = gmask;
    next_saved_pc = saved_pc;
    next_ack      = '0;
    next_pc_load  = 1'b0;
    next_pc_value = o_pc_value;
    next_nmi_pend = nmi_pend | nmi_evt;

    case (state)
      ICFM_IDLE: begin
        if (i_core_ready && nmi_pend) begin
          next_nmi_pend        = nmi_evt;
          next_ack.ack         = 1'b1;
          next_ack.nmi         = 1'b1;
          next_ack.vector_addr = NMI_VEC;
          next_state           = ICFM_ACK;
        end else if (i_core_ready && (eligible != 16'h0000)) begin
          clr_ack              = onehot(sel);
          next_ack.ack         = 1'b1;
          next_ack.line        = sel;
          next_ack.vector_addr = VEC_BASE + 16'({12'h000, sel} << VEC_SHIFT);
          next_gmask           = 1'b1;
          next_state           = ICFM_ACK;
        end
        if (next_ack.ack) begin
          next_saved_pc = i_cur_pc;
          next_pc_load  = 1'b1;
          next_pc_value = next_ack.vector_addr;
        end
      end
      ICFM_ACK: begin
        next_state = ICFM_SERVE;
      end
      ICFM_SERVE: begin
        if (i_return) begin
          next_pc_load  = 1'b1;
          next_pc_value = saved_pc;
          next_state    = ICFM_IDLE;
        end
      end
      default: begin
        next_state = ICFM_IDLE;
      end
    endcase

    if (i_wr.gmask_wr) begin
      next_gmask = i_wr.gmask_val;
    end
    next_enmask = i_wr.mask_wr ? i_wr.data : enmask;

    next_pend = pend & ~clr_ack;
    if (i_wr.pend_wr) begin
      next_pend = next_pend & ~i_wr.data;
    end
    next_pend = next_pend | set_vec;
    next_in_service = (next_state != ICFM_IDLE);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state                            <= ICFM_IDLE;
      pend                             <= PEND_RST;
      enmask                           <= ENMASK_RST;
      gmask                            <= GMASK_RST;
      nmi_pend                         <= 1'b0;
      saved_pc                         <= PC_RST;
      o_vector_fetch_ack               <= '0;
      o_pc_load                        <= 1'b0;
      o_pc_value                       <= PC_RST;
      o_pending_flag_register          <= PEND_RST;
      o_interrupt_enable_mask_register <= ENMASK_RST;
      o_global_mask_bit                <= GMASK_RST;
      o_in_service                     <= 1'b0;
    end else begin
      state                            <= next_state;
      pend                             <= next_pend;
      enmask                           <= next_enmask;
      gmask                            <= next_gmask;
      nmi_pend                         <= next_nmi_pend;
      saved_pc                         <= next_saved_pc;
      o_vector_fetch_ack               <= next_ack;
      o_pc_load                        <= next_pc_load;
      o_pc_value                       <= next_pc_value;
      o_pending_flag_register          <= next_pend;
      o_interrupt_enable_mask_register <= next_enmask;
      o_global_mask_bit                <= next_gmask;
      o_in_service                     <= next_in_service;
    end
  end
endmodule // icfm_ctrl
`default_nettype wire

// ===== icfm_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module icfm_ctrl_asserts
  import icfm_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_sys_rst,
  input wire icfm_pkg::icfm_wr_t  i_wr,
  input wire logic [15:0]         i_periph_req,
  input wire logic                i_return,
  input wire logic [15:0]         o_pending_flag_register,
  input wire logic [15:0]         o_interrupt_enable_mask_register,
  input wire logic                o_global_mask_bit,
  input wire icfm_pkg::icfm_ack_t o_vector_fetch_ack,
  input wire logic                o_pc_load,
  input wire logic [15:0]         o_pc_value,
  input wire logic                o_in_service
);
  import icfm_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic        ak;
  logic        an;
  logic [15:0] av;
  logic [15:0] ab;
  logic [15:0] clr;
  assign ak  = o_vector_fetch_ack.ack;
  assign an  = o_vector_fetch_ack.nmi;
  assign av  = o_vector_fetch_ack.vector_addr;
  // flag dropped by the acknowledge itself
  assign ab  = (ak && !an) ? 16'h0001 << o_vector_fetch_ack.line : 16'h0000;
  assign clr = i_wr.pend_wr ? i_wr.data : 16'h0000;
  AST_ACK_PULSE: assert property (ak |=> !ak) else $error("ack too long");
  AST_ACK_VEC: assert property (
    ak |-> av == (an ? NMI_VEC : VEC_BASE + (16'(o_vector_fetch_ack.line) << 1)))
    else $error("bad vector");
  AST_PC_LOAD: assert property (
    ak |-> o_pc_load && o_pc_value == av && o_in_service)
    else $error("no pc load");
  AST_ELIG: assert property (
    ak && !an |-> !$past(o_global_mask_bit) && |($past(o_interrupt_enable_mask_register) & ab))
    else $error("masked accepted");
  AST_MASK_WR: assert property (
    i_wr.mask_wr |=> o_interrupt_enable_mask_register == $past(i_wr.data))
    else $error("mask write");
  AST_CLEAR: assert property (
    i_wr.pend_wr |=> (o_pending_flag_register & $past(i_wr.data & ~i_periph_req)) == 16'h0000)
    else $error("no clear");
  AST_HOLD: assert property (
    (~o_pending_flag_register & $past(o_pending_flag_register) & ~$past(clr) & ~ab) == 16'h0000)
    else $error("flag lost");
  AST_RETURN: assert property (
    o_in_service && i_return && !ak && !$past(ak) |=> o_pc_load && !o_in_service)
    else $error("no return");
  cover property (ak && an);
  cover property (ak && !an);
  cover property (o_in_service && i_return);
endmodule // icfm_ctrl_asserts
bind icfm_ctrl icfm_ctrl_asserts i_chk (.*);
`default_nettype wire

// ===== icfm_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module icfm_src_model (
  // control from bench
  input  wire logic       i_clock,
  input  wire logic       i_fire,
  input  wire logic [1:0] i_kind,
  input  wire logic [3:0] i_line,
  // request wires
  output var logic [15:0] o_pin_req = 16'h0000,
  output var logic [15:0] o_periph_req = 16'h0000,
  output var logic        o_nmi_pin = 1'h0
);
  logic [2:0] hold = 3'h0;
  always @(posedge i_clock) begin
    o_periph_req <= (i_fire && i_kind == 2'h0) ? 16'h0001 << i_line : 16'h0000;
    hold <= i_fire ? 3'h5 : hold - {2'h0, hold != 3'h0};
    if (i_fire && i_kind == 2'h1) o_pin_req <= 16'h0001 << i_line;
    else if (hold == 3'h1) o_pin_req <= 16'h0000;
    if (i_fire && i_kind == 2'h2) o_nmi_pin <= 1'h1;
    else if (hold == 3'h1) o_nmi_pin <= 1'h0;
  end
endmodule // icfm_src_model
`default_nettype wire

// ===== cpu_interrupt_flag_mask_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_flag_mask_logic_tb_top;
  import icfm_pkg::*;
  logic        clk = 1'h0, rst = 1'h1, fire = 1'h0, swi = 1'h0, trap = 1'h0, nmii = 1'h0, ret = 1'h0;
  logic [1:0]  kind = 2'h0;
  logic        rdy = 1'h1;
  logic [3:0]  line = 4'h0, sline = 4'h0;
  logic [15:0] cpc = 16'h0000, pin, per, pend, mask, pcv;
  logic        nmip, gm, pcl, insv, found;
  icfm_wr_t    wr = '0;
  icfm_ack_t   ack;
  int          mismatches = 0, total_checks = 0;
  always #5 clk = ~clk;
  icfm_src_model i_src (.i_clock(clk), .i_fire(fire), .i_kind(kind), .i_line(line), .o_pin_req(pin),
    .o_periph_req(per), .o_nmi_pin(nmip));
  icfm_ctrl i_dut (.i_clock(clk), .i_sys_rst(rst), .i_pin_req(pin), .i_periph_req(per), .i_nmi_pin(nmip),
    .i_swi_valid(swi), .i_swi_line(sline), .i_trap_valid(trap), .i_nmi_instr(nmii), .i_wr(wr),
    .i_core_ready(rdy), .i_cur_pc(cpc), .i_return(ret), .o_pending_flag_register(pend),
    .o_interrupt_enable_mask_register(mask), .o_global_mask_bit(gm), .o_vector_fetch_ack(ack),
    .o_pc_load(pcl), .o_pc_value(pcv), .o_in_service(insv));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrt(input logic p, input logic m, input logic [15:0] d);
    wr = '{p, m, 1'b0, 1'b0, d};
    step(1);
    wr = '0;
    step(1);
  endtask
  // writes the global mask, then waits for one acceptance and drives its return
  task automatic serve(input int src, input logic [15:0] ln, input logic gv, input logic [15:0] vec, input logic nm);
    found = 0;
    cpc = vec + 16'h1000;
    trap = (src == 1);
    nmii = (src == 2);
    fire = (src == 3);
    kind = 2'h2;
    wr = '{1'b0, 1'b0, 1'b1, gv, 16'h0000};
    step(1);
    {trap, nmii, fire} = 3'h0;
    wr = '0;
    for (int i = 0; i < 12 && !found; i++) begin
      step(1);
      found = (ack.ack === 1'b1);
    end
    chk({15'h0, found}, 16'h0001);
    if (!found) summarize();
    chk(ack.vector_addr, vec);
    chk(pcv, vec);
    chk({15'h0, ack.nmi}, {15'h0, nm});
    chk({12'h0, ack.line}, ln);
    chk({13'h0, pcl, insv, gm}, 16'h0007);
    step(2);
    ret = 1;
    step(1);
    ret = 0;
    chk(pcv, cpc);
    chk({14'h0, insv, pcl}, 16'h0001);
  endtask
  task automatic t_flags;
    fire = 1;
    step(1);
    fire = 0;
    step(2);
    chk(pend, 16'h0001);
    step(6);
    chk(pend, 16'h0001);
    wrt(1, 0, 16'hFFFE);
    chk(pend, 16'h0001);
    wrt(1, 0, 16'h0001);
    chk(pend, 16'h0000);
  endtask
  task automatic t_accept;
    wrt(0, 1, 16'h0088);
    chk(mask, 16'h0088);
    swi = 1;
    sline = 4'h7;
    fire = 1;
    kind = 2'h1;
    line = 4'h3;
    step(1);
    {swi, fire} = 2'h0;
    step(8);
    chk(pend, 16'h0088);
    chk({15'h0, insv}, 16'h0000);
    // core busy: eligible lines must wait; mask set again before ready returns
    rdy = 1'h0;
    wr = '{1'b0, 1'b0, 1'b1, 1'b0, 16'h0000};
    step(3);
    wr.gmask_val = 1'b1;
    step(1);
    wr = '0;
    rdy = 1'h1;
    chk({14'h0, insv, ack.ack}, 16'h0000);
    serve(0, 16'h0003, 0, 16'h0008, 0);
    serve(0, 16'h0007, 0, 16'h0010, 0);
    chk(pend, 16'h0000);
  endtask
  task automatic t_reset;
    fire = 1'h1;
    kind = 2'h0;
    line = 4'h5;
    step(1);
    fire = 1'h0;
    step(2);
    chk(pend, 16'h0020);
    rst = 1'h1;
    step(2);
    rst = 1'h0;
    chk(pend, 16'h0000);
    chk({mask[14:0], gm}, 16'h0001);
  endtask
  task automatic t_nmi;
    for (int s = 1; s < 4; s++) serve(s, 16'h0000, 1, NMI_VEC, 1);
  endtask
  initial begin
    step(5);
    rst = 0;
    chk(pend, 16'h0000);
    chk({mask[14:0], gm}, 16'h0001);
    t_flags();
    t_accept();
    t_reset();
    t_nmi();
    summarize();
  end
endmodule // cpu_interrupt_flag_mask_logic_tb_top
`default_nettype wire
